// ===== src/motor_cmd_regs.svh
`ifndef MOTOR_CMD_REGS_SVH
`define MOTOR_CMD_REGS_SVH

// ----------------------------------------------------------------
// command codes
// ----------------------------------------------------------------
`define CMD_PHASE_STATUS   8'h9d
`define CMD_SHUTDOWN       8'h80
`define CMD_STOP           8'h81
`define CMD_TORQUE         8'ha1

// ----------------------------------------------------------------
// frame addressing and serial framing
// ----------------------------------------------------------------
`define CAN_REQ_BASE       11'h140
`define CAN_RSP_BASE       11'h240
`define SER_HEADER         8'h3e
`define SER_LENGTH         8'h08
`define SER_LAST_IDX       4'hc
`define CRC_INIT           16'hffff
`define CRC_POLY           16'ha001
`define ANGLE_MAX          32'sh00007fff
`define ANGLE_MIN          (-32'sh00007fff)

// ----------------------------------------------------------------
// apb register offsets, fields and reset values
// ----------------------------------------------------------------
`define REG_CFG            12'h000
`define REG_STATUS         12'h004
`define REG_SETPOINT       12'h008
`define REG_LAST_CMD       12'h00c
`define REG_ACCEPT_CNT     12'h010
`define REG_REJECT_CNT     12'h014
`define CFG_ID_RST         8'h01
`define ST_ENABLE_BIT      0
`define ST_RUNNING_BIT     1
`define ST_TORQUE_BIT      2
`define ST_FAULT_BIT       3
`define ST_PENDING_BIT     4

`endif

// ===== src/motor_cmd_pkg.sv
package motor_cmd_pkg;

  typedef enum logic [1:0] {RS_IDLE, RS_CAN, RS_SERIAL} reply_state_t;
  typedef enum logic {DM_OFF, DM_TORQUE} drive_mode_t;

  typedef struct packed {
    reply_state_t st;
    drive_mode_t  mode;
    logic         enable;
    logic         running;
    logic [7:0]   motor_id;
    logic [15:0]  setpoint;
    logic [63:0]  rsp_data;
    logic [10:0]  rsp_id;
    logic [7:0]   last_cmd;
    logic [15:0]  accept_cnt;
    logic [15:0]  reject_cnt;
    logic [31:0]  prdata;
  } cmd_state_t;

  typedef struct packed {
    logic         busy;
    logic [3:0]   idx;
    logic [15:0]  crc;
    logic [63:0]  data;
    logic [7:0]   id;
    logic [7:0]   tx_byte;
  } framer_t;

endpackage : motor_cmd_pkg

// ===== src/serial_reply_framer.sv
`timescale 1ns/1ps
`include "motor_cmd_regs.svh"

module serial_reply_framer
  import motor_cmd_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // reply to send
  input  wire logic        start_valid,
  output logic             start_ready,
  input  wire logic [7:0]  frame_id,
  input  wire logic [63:0] frame_data,
  // byte stream to the line driver
  output logic             tx_valid,
  input  wire logic        tx_ready,
  output logic [7:0]       tx_byte
);

  framer_t s, n;

  // one byte of modbus-style crc, reflected polynomial
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++)
    begin
      r = r[0] ? ((r >> 1) ^ `CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crc_step

  // byte at a given position of the frame, before the check bytes
  function automatic logic [7:0] pick(input framer_t f, input logic [3:0] i);
    logic [3:0] k;
    k = i - 4'h3;
    if (i == 4'h1) return f.id;
    else if (i == 4'h2) return `SER_LENGTH;
    else return f.data[{k[2:0], 3'b000} +: 8];
  endfunction : pick

  assign start_ready = !s.busy;
  assign tx_valid    = s.busy;
  assign tx_byte     = s.tx_byte;

  always_comb
  begin
    n = s;
    if (!s.busy && start_valid)
    begin
      n.busy    = 1'b1;
      n.idx     = 4'h0;
      n.id      = frame_id;
      n.data    = frame_data;
      n.tx_byte = `SER_HEADER;
      n.crc     = crc_step(`CRC_INIT, `SER_HEADER);
    end
    else if (s.busy && tx_ready)
    begin
      n.idx = s.idx + 4'h1;
      if (s.idx == `SER_LAST_IDX)
        n.busy = 1'b0;
      else if (s.idx == 4'ha)
        n.tx_byte = s.crc[7:0];
      else if (s.idx == 4'hb)
        n.tx_byte = s.crc[15:8];
      else
      begin
        n.tx_byte = pick(s, n.idx);
        n.crc     = crc_step(s.crc, n.tx_byte);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s <= '0;
    else
      s <= n;
  end

  a_header_first : assert property (@(posedge pclk) disable iff (!presetn)
    start_valid && start_ready |=> tx_valid && tx_byte == `SER_HEADER ##1 1'b1)
    else $error("serial frame does not open with header");

endmodule : serial_reply_framer

// ===== src/motor_cmd_top.sv
// Design decisions made here: the APB slave port and the register addresses.
`timescale 1ns/1ps
`include "motor_cmd_regs.svh"

module motor_cmd_top
  import motor_cmd_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // request frame from the link layer
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire logic        req_from_serial,
  input  wire logic [10:0] req_id,
  input  wire logic [63:0] req_data,
  // can reply frame
  output logic             rsp_valid,
  input  wire logic        rsp_ready,
  output logic [10:0]      rsp_id,
  output logic [63:0]      rsp_data,
  // serial reply byte stream
  output logic             tx_valid,
  input  wire logic        tx_ready,
  output logic [7:0]       tx_byte,
  // measurements from the drive
  input  wire logic [7:0]  motor_temp,
  input  wire logic [15:0] phase_a_current,
  input  wire logic [15:0] phase_b_current,
  input  wire logic [15:0] phase_c_current,
  input  wire logic [15:0] measured_torque_current,
  input  wire logic [15:0] shaft_speed,
  input  wire logic [31:0] shaft_angle,
  input  wire logic        motor_fault,
  // drive control
  output logic             motor_enable,
  output logic             motor_running,
  output logic             torque_mode,
  output logic [15:0]      torque_current_setpoint
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] clamp_angle(input logic [31:0] a);
    if ($signed(a) > `ANGLE_MAX) return 16'h7fff;
    else if ($signed(a) < `ANGLE_MIN) return 16'h8001;
    else return a[15:0];
  endfunction : clamp_angle

  function automatic logic addr_mapped(input logic [11:0] a);
    return a == `REG_CFG || a == `REG_STATUS || a == `REG_SETPOINT ||
           a == `REG_LAST_CMD || a == `REG_ACCEPT_CNT || a == `REG_REJECT_CNT;
  endfunction : addr_mapped

  function automatic logic [10:0] can_id(input logic [10:0] base, input logic [7:0] id);
    return base + {3'b000, id};
  endfunction : can_id

  cmd_state_t s, n;

  logic       frm_start;
  logic       frm_ready;
  logic       addressed;
  logic       well_formed;
  logic       offered;
  logic       take;
  logic [7:0] cmd;

  // ----------------------------------------------------------------
  // frame decode
  // ----------------------------------------------------------------
  assign cmd       = req_data[7:0];
  assign req_ready = (s.st == RS_IDLE);
  assign offered   = req_valid && req_ready;
  assign addressed = req_from_serial ? (req_id[7:0] == s.motor_id)
                                     : (req_id == can_id(`CAN_REQ_BASE, s.motor_id));

  always_comb
  begin
    unique case (cmd)
      `CMD_PHASE_STATUS,
      `CMD_SHUTDOWN,
      `CMD_STOP:         well_formed = (req_data[63:8] == 56'h0);
      `CMD_TORQUE:       well_formed = (req_data[31:8] == 24'h0) &&
                                       (req_data[63:48] == 16'h0) && !motor_fault;
      default:           well_formed = 1'b0;
    endcase
  end

  assign take = offered && addressed && well_formed;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    n = s;
    unique case (s.st)
      RS_IDLE:
      begin
        if (take)
        begin
          n.st         = req_from_serial ? RS_SERIAL : RS_CAN;
          n.rsp_id     = can_id(`CAN_RSP_BASE, s.motor_id);
          n.last_cmd   = cmd;
          n.accept_cnt = s.accept_cnt + 16'h0001;
          n.rsp_data   = req_data;
          unique case (cmd)
            `CMD_PHASE_STATUS:
              n.rsp_data = {phase_c_current, phase_b_current,
                            phase_a_current, motor_temp, cmd};
            `CMD_SHUTDOWN:
            begin
              n.enable  = 1'b0;
              n.running = 1'b0;
              n.mode    = DM_OFF;
            end
            `CMD_STOP:
              n.running = 1'b0;
            `CMD_TORQUE:
            begin
              n.setpoint = req_data[47:32];
              n.mode     = DM_TORQUE;
              n.enable   = 1'b1;
              n.running  = 1'b1;
              n.rsp_data = {clamp_angle(shaft_angle), shaft_speed,
                            measured_torque_current, motor_temp, cmd};
            end
            default: n.rsp_data = req_data;
          endcase
        end
        else if (offered && addressed)
          n.reject_cnt = s.reject_cnt + 16'h0001;
      end
      RS_CAN:
        if (rsp_ready) n.st = RS_IDLE;
      RS_SERIAL:
        if (frm_ready) n.st = RS_IDLE;
      default: n.st = RS_IDLE;
    endcase

    // apb: read data latched in the setup phase, writes take in access
    if (psel && !penable && !pwrite)
    begin
      unique case (paddr)
        `REG_CFG:        n.prdata = {24'h0, s.motor_id};
        `REG_STATUS:     n.prdata = {27'h0, s.st != RS_IDLE, motor_fault,
                                     s.mode == DM_TORQUE, s.running, s.enable};
        `REG_SETPOINT:   n.prdata = {16'h0, s.setpoint};
        `REG_LAST_CMD:   n.prdata = {24'h0, s.last_cmd};
        `REG_ACCEPT_CNT: n.prdata = {16'h0, s.accept_cnt};
        `REG_REJECT_CNT: n.prdata = {16'h0, s.reject_cnt};
        default:         n.prdata = 32'h0;
      endcase
    end
    if (psel && penable && pwrite && paddr == `REG_CFG)
      n.motor_id = pwdata[7:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s          <= '0;
      s.motor_id <= `CFG_ID_RST;
    end
    else
      s <= n;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata                  = s.prdata;
  assign pready                  = 1'b1;
  assign pslverr                 = psel && penable && !addr_mapped(paddr);
  assign rsp_valid               = (s.st == RS_CAN);
  assign rsp_id                  = s.rsp_id;
  assign rsp_data                = s.rsp_data;
  assign frm_start               = (s.st == RS_SERIAL);
  assign motor_enable            = s.enable;
  assign motor_running           = s.running;
  assign torque_mode             = (s.mode == DM_TORQUE);
  assign torque_current_setpoint = s.setpoint;

  serial_reply_framer u_framer (
    .pclk        (pclk),
    .presetn     (presetn),
    .start_valid (frm_start),
    .start_ready (frm_ready),
    .frame_id    (s.motor_id),
    .frame_data  (s.rsp_data),
    .tx_valid    (tx_valid),
    .tx_ready    (tx_ready),
    .tx_byte     (tx_byte)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_take(logic [7:0] c);
    take && cmd == c;
  endsequence

  sequence s_torque_try;
    offered && addressed && cmd == `CMD_TORQUE && motor_fault;
  endsequence

  sequence s_serial_take;
    take && req_from_serial;
  endsequence

  sequence s_serial_handoff;
    frm_start && !req_ready;
  endsequence

  a_phase_reply : assert property (s_take(`CMD_PHASE_STATUS) |=>
    rsp_data[7:0] == `CMD_PHASE_STATUS && rsp_data[31:16] == $past(phase_a_current) &&
    rsp_data[47:32] == $past(phase_b_current) && rsp_data[63:48] == $past(phase_c_current))
    else $error("phase reply layout wrong");

  a_temp_byte : assert property (s_take(`CMD_PHASE_STATUS) or s_take(`CMD_TORQUE) |=>
    rsp_data[15:8] == $past(motor_temp))
    else $error("temperature byte wrong");

  a_shutdown_off : assert property (s_take(`CMD_SHUTDOWN) |=>
    !motor_enable && !motor_running && !torque_mode)
    else $error("shutdown left the motor active");

  a_echo_reply : assert property (s_take(`CMD_SHUTDOWN) or s_take(`CMD_STOP) |=>
    rsp_data == $past(req_data))
    else $error("reply is not a copy of the request");

  a_stop_keeps_mode : assert property (s_take(`CMD_STOP) |=>
    !motor_running && torque_mode == $past(torque_mode))
    else $error("stop changed mode or left motor running");

  a_fault_blocks : assert property (s_torque_try |=>
    torque_current_setpoint == $past(torque_current_setpoint) && !rsp_valid)
    else $error("torque command ran during a fault");

  a_setpoint_taken : assert property (s_take(`CMD_TORQUE) |=>
    torque_current_setpoint == $past(req_data[47:32]) && torque_mode && motor_enable)
    else $error("torque setpoint not adopted");

  a_torque_reply : assert property (s_take(`CMD_TORQUE) |=>
    rsp_data[7:0] == `CMD_TORQUE && rsp_data[31:16] == $past(measured_torque_current) &&
    rsp_data[47:32] == $past(shaft_speed))
    else $error("torque reply fields wrong");

  // angle must saturate at the symmetric limits, never wrap
  a_angle_limit : assert property (s_take(`CMD_TORQUE) |=>
    (($signed($past(shaft_angle)) > 32'sd32767) ? rsp_data[63:48] == 16'h7fff :
     ($signed($past(shaft_angle)) < -32'sd32767) ? rsp_data[63:48] == 16'h8001 :
     rsp_data[63:48] == $past(shaft_angle[15:0])) && rsp_data[63:48] != 16'h8000)
    else $error("angle not limited");

  a_reply_held : assert property (rsp_valid && !rsp_ready |=>
    rsp_valid && $stable(rsp_data) && $stable(rsp_id))
    else $error("can reply dropped or changed");

  a_can_reply_id : assert property (take && !req_from_serial |=>
    rsp_valid && rsp_id == `CAN_RSP_BASE + {3'b000, $past(s.motor_id)})
    else $error("can reply identifier wrong");

  a_serial_start : assert property (s_serial_take |=> s_serial_handoff)
    else $error("serial reply not handed to the framer");

  a_id_write : assert property (psel && penable && pwrite && paddr == `REG_CFG |=>
    s.motor_id == $past(pwdata[7:0]))
    else $error("motor number write lost");

  a_refuse_counted : assert property (offered && addressed && !well_formed |=>
    s.reject_cnt == $past(s.reject_cnt) + 16'h0001 && !rsp_valid)
    else $error("refused frame not counted");

  // drive outputs move only on an accepted command
  a_drive_held : assert property (!take |=>
    $stable(torque_current_setpoint) && $stable(torque_mode) && $stable(motor_enable))
    else $error("drive state changed without a command");

endmodule : motor_cmd_top

// ===== sim/host_link_model.sv
`timescale 1ns/1ps

module host_link_model (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // request frame
  output logic             req_valid,
  input  wire logic        req_ready,
  output logic             req_from_serial,
  output logic [10:0]      req_id,
  output logic [63:0]      req_data,
  // replies
  input  wire logic        rsp_valid,
  output logic             rsp_ready,
  input  wire logic [10:0] rsp_id,
  input  wire logic [63:0] rsp_data,
  input  wire logic        tx_valid,
  output logic             tx_ready,
  input  wire logic [7:0]  tx_byte
);
  logic        slow = 1'b0;
  int          rx_cnt = 0;
  logic [10:0] rx_id;
  logic [63:0] rx_data;
  logic [7:0]  ser_q[$];

  initial
  begin
    req_valid = 1'b0;
    req_from_serial = 1'b0;
    req_id = 11'h0;
    req_data = 64'h0;
    rsp_ready = 1'b0;
    tx_ready = 1'b0;
  end

  // offer one frame and hold it until taken; garble the lines afterwards
  task automatic send(input logic ser, input logic [10:0] id, input logic [63:0] d);
    req_valid <= 1'b1;
    req_from_serial <= ser;
    req_id <= id;
    req_data <= d;
    @(posedge pclk);
    while (req_ready !== 1'b1)
      @(posedge pclk);
    req_valid <= 1'b0;
    req_id <= ~id;
    req_data <= ~d;
  endtask : send

  // slow mode stalls every other cycle
  always @(posedge pclk)
  begin
    rsp_ready <= presetn && (slow ? ~rsp_ready : 1'b1);
    tx_ready <= presetn && (slow ? ~tx_ready : 1'b1);
    if (rsp_valid && rsp_ready)
    begin
      rx_cnt <= rx_cnt + 1;
      rx_id <= rsp_id;
      rx_data <= rsp_data;
    end
    if (tx_valid && tx_ready)
      ser_q.push_back(tx_byte);
  end
endmodule : host_link_model

// ===== sim/motor_status_and_torque_cmd_test.sv
`timescale 1ns/1ps
`include "motor_cmd_regs.svh"

module motor_status_and_torque_cmd_test;
  logic        pclk = 1'b0, presetn = 1'b0, pready, pslverr;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, shaft_angle = 32'hffffffd3;
  logic        req_valid, req_ready, req_from_serial, rsp_valid, rsp_ready, tx_valid;
  logic        tx_ready, motor_fault = 1'b0, motor_enable, motor_running, torque_mode;
  logic [10:0] req_id, rsp_id;
  logic [63:0] req_data, rsp_data;
  logic [7:0]  tx_byte, motor_temp = 8'h32;
  logic [15:0] phase_a_current = 16'h0bc2, phase_b_current = 16'hfa10;
  logic [15:0] phase_c_current = 16'hf9c0, measured_torque_current = 16'hff9c;
  logic [15:0] shaft_speed = 16'hfe0c, torque_current_setpoint;
  int          num_errors = 0;
  int          total_checks = 0;

  motor_cmd_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .req_valid, .req_ready, .req_from_serial, .req_id, .req_data,
    .rsp_valid, .rsp_ready, .rsp_id, .rsp_data, .tx_valid, .tx_ready, .tx_byte, .motor_temp,
    .phase_a_current, .phase_b_current, .phase_c_current, .measured_torque_current,
    .shaft_speed, .shaft_angle, .motor_fault, .motor_enable, .motor_running, .torque_mode,
    .torque_current_setpoint);
  host_link_model host (.pclk, .presetn, .req_valid, .req_ready, .req_from_serial, .req_id,
    .req_data, .rsp_valid, .rsp_ready, .rsp_id, .rsp_data, .tx_valid, .tx_ready, .tx_byte);

  always #12.5 pclk = ~pclk;

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // send one can frame, wait a bounded time for a reply
  task automatic can(input logic [63:0] d, input logic [10:0] id, output logic got);
    int n0;
    n0 = host.rx_cnt;
    @(posedge pclk);
    host.send(1'b0, id, d);
    repeat (12)
      if (host.rx_cnt == n0)
        @(posedge pclk);
    got = (host.rx_cnt != n0);
  endtask : can

  task stop_test;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : stop_test

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_phase;
    logic g;
    host.slow = 1'b1;
    can({56'h0, `CMD_PHASE_STATUS}, 11'h141, g);
    chk(64'(g), 64'h1);
    chk(64'(host.rx_id), 64'h241);
    chk(host.rx_data, 64'hf9c0fa100bc2329d);
    host.slow = 1'b0;
    $display("phase status test done");
  endtask : t_phase

  task automatic t_torque;
    logic        g;
    logic [31:0] ang[3] = '{32'hffffffd3, 32'd40000, 32'hffff63c0};
    logic [15:0] ea[3] = '{16'hffd3, 16'h7fff, 16'h8001};
    logic        e;
    logic [31:0] rd;
    for (int i = 0; i < 3; i++)
    begin
      shaft_angle <= ang[i];
      can(64'h0000ff9c000000a1, 11'h141, g);
      chk(64'(g), 64'h1);
      chk(host.rx_data, {ea[i], 40'hfe0cff9c32, `CMD_TORQUE});
    end
    chk(64'(torque_current_setpoint), 64'hff9c);
    chk(64'({torque_mode, motor_running, motor_enable}), 64'h7);
    apb(1'b0, `REG_STATUS, 32'h0, rd, e);
    chk(64'({rd, e}), 64'he);
    apb(1'b0, `REG_SETPOINT, 32'h0, rd, e);
    chk(64'(rd), 64'hff9c);
    apb(1'b0, `REG_LAST_CMD, 32'h0, rd, e);
    chk(64'(rd), 64'(`CMD_TORQUE));
    apb(1'b0, `REG_ACCEPT_CNT, 32'h0, rd, e);
    chk(64'(rd), 64'h4);
    $display("torque test done");
  endtask : t_torque

  task automatic t_refuse;
    logic        g;
    logic        e;
    logic [31:0] rd;
    motor_fault <= 1'b1;
    can(64'h00000064000000a1, 11'h141, g);
    chk(64'(g), 64'h0);
    chk(64'(torque_current_setpoint), 64'hff9c);
    motor_fault <= 1'b0;
    can(64'h000000000000019d, 11'h141, g);
    chk(64'(g), 64'h0);
    can(64'h9d, 11'h142, g);
    chk(64'(g), 64'h0);
    apb(1'b0, `REG_REJECT_CNT, 32'h0, rd, e);
    chk(64'(rd), 64'h2);
    apb(1'b0, 12'h018, 32'h0, rd, e);
    chk(64'({rd, e}), 64'h1);
    apb(1'b0, `REG_CFG, 32'h0, rd, e);
    chk(64'(rd), 64'h1);
    apb(1'b1, `REG_CFG, 32'h2, rd, e);
    can(64'h9d, 11'h142, g);
    chk(64'(host.rx_id), 64'h242);
    apb(1'b1, `REG_CFG, 32'h1, rd, e);
    $display("refusal test done");
  endtask : t_refuse

  task automatic t_halt;
    logic       g;
    logic [7:0] cmd[2] = '{`CMD_STOP, `CMD_SHUTDOWN};
    logic [2:0] fl[2] = '{3'h5, 3'h0};
    for (int i = 0; i < 2; i++)
    begin
      can({56'h0, cmd[i]}, 11'h141, g);
      chk(host.rx_data, {56'h0, cmd[i]});
      chk(64'({torque_mode, motor_running, motor_enable}), 64'(fl[i]));
    end
    $display("stop and shutdown test done");
  endtask : t_halt

  task automatic t_serial;
    logic [7:0]  e[13] = '{8'h3e, 8'h01, 8'h08, 8'h9d, 8'h32, 8'hc2, 8'h0b, 8'h10, 8'hfa,
                           8'hc0, 8'hf9, 8'h00, 8'h00};
    logic [15:0] c = 16'hffff;
    int          n = 0;
    for (int i = 0; i < 11; i++)
    begin
      c = c ^ {8'h0, e[i]};
      for (int k = 0; k < 8; k++)
        c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
    end
    e[11] = c[7:0];
    e[12] = c[15:8];
    host.slow = 1'b1;
    @(posedge pclk);
    host.send(1'b1, 11'h001, {56'h0, `CMD_PHASE_STATUS});
    while (host.ser_q.size() < 13 && n < 100)
    begin
      @(posedge pclk);
      n++;
    end
    chk(64'(host.ser_q.size()), 64'd13);
    for (int i = 0; i < 13 && i < host.ser_q.size(); i++)
      chk(64'(host.ser_q[i]), 64'(e[i]));
    host.slow = 1'b0;
    $display("serial test done");
  endtask : t_serial

  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_phase();
    t_torque();
    t_refuse();
    t_halt();
    t_serial();
    stop_test();
  end

  initial
  begin
    #(25 * 3000);
    num_errors++;
    stop_test();
  end
endmodule : motor_status_and_torque_cmd_test
